/* File: design/brsc_regs.vh */
// Offsets, field positions, reset values and codes of the reset/standby block
// Assumes a 16-bit special function register space addressed in bytes
`ifndef BRSC_REGS_VH
`define BRSC_REGS_VH
`define BRSC_ADDR_W 16
`define BRSC_OFF_RST_TWO 16'hF07C
`define BRSC_OFF_RST_THREE 16'hF07E
`define BRSC_OFF_CKG_TWO 16'hF074
`define BRSC_OFF_CKG_THREE 16'hF076
`define BRSC_OFF_STBY 16'hF010
`define BRSC_OFF_UNLOCK 16'hF012
`define BRSC_OFF_CLKCTL 16'hF014
`define BRSC_OFF_MODE 16'hF016
`define BRSC_RST_TWO_MASK 16'hE83F
`define BRSC_RST_THREE_MASK 16'h003F
`define BRSC_REG_RESET 16'h0000
`define BRSC_STBY_HALT_BIT 0
`define BRSC_STBY_HALTH_BIT 1
`define BRSC_STBY_STOP_BIT 2
`define BRSC_CLK_FOSC_BIT 0
`define BRSC_CLK_SEL_BIT 1
`define BRSC_UNLOCK_FIRST 4'h5
`define BRSC_UNLOCK_SECOND 4'hA
`endif

/* File: design/brsc_rst_reg.v */
// One 16-bit reset or clock-gate register with byte-lane writes
// Assumes writes come from the same clock domain; mask marks real bits
module brsc_rst_reg #(
    parameter [15:0] IMPL_MASK = 16'hFFFF
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire wr_i,
    input wire [1:0] lane_i,
    input wire [15:0] wdata_i,
    output wire [15:0] q_o
);
    reg [15:0] val_reg;
    wire [15:0] lane_mask;
    assign lane_mask = {{8{lane_i[1]}}, {8{lane_i[0]}}};
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            val_reg <= 16'h0000;
        end else if (wr_i) begin
            // Absent and reserved bits stay zero
            val_reg <= (val_reg & ~lane_mask)
                | (wdata_i & lane_mask & IMPL_MASK);
        end
    end
    assign q_o = val_reg;
endmodule // brsc_rst_reg

/* File: design/brsc_top.v */
// Block reset registers and the run/HALT/HALT-H/STOP mode sequencer
// Assumes the CPU bus and all wake sources are synchronous to core_clk_i
//
// The address-and-strobe port is this design's own decision.
`include "brsc_regs.vh"

// How it works
// RQ1: Absent peripheral bits ignore writes, read zero
// RQ2: Bit one holds peripheral reset; resets zero
// RQ3: Second register: DMA, buzzer, muldiv, CRC, serials
// RQ4: Third register: comparators, DACs, LCD, ADC
// RQ5: Byte or word access; both reset zero
// RQ6: Software resets, ungates clock, then releases
// RQ7: Clock-gate bit one stops peripheral clock
// RQ8: Reset release enters program run mode
// RQ9: Wake interrupt returns standby to run
// RQ10: Halt bit stops CPU, peripherals keep clock
// RQ11: Watchdog or enabled irq ends HALT
// RQ12: HALT-H stops CPU and fast clock
// RQ13: Irq ends HALT-H, fast clock restarts
// RQ14: HALT-H exit forces oscillator and select on
// RQ15: STOP halts every clock
// RQ16: Unlock 5n then An before stop bit
// RQ17: Software clears master irq before STOP
// RQ18: STOP wakes only on listed sources
// RQ19: Unarmed stop write ignored; misorder disarms
// RQ20: Reserved bits read zero, ignore writes
module brsc_top #(
    parameter [15:0] RST_TWO_AVAIL = 16'hFFFF,
    parameter [15:0] RST_THREE_AVAIL = 16'hFFFF
) (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    input wire [1:0] byte_en_i,
    input wire wr_i,
    input wire rd_i,
    input wire wdt_irq_i,
    input wire enabled_irq_i,
    input wire ext_irq_i,
    input wire vls_irq_i,
    input wire cmp_irq_i,
    input wire i2c_slave_irq_i,
    output reg [15:0] rdata_o,
    output reg [15:0] block_reset_ctrl_two_o,
    output reg [15:0] block_reset_ctrl_three_o,
    output reg [15:0] block_clock_gate_two_o,
    output reg [15:0] block_clock_gate_three_o,
    output reg cpu_run_o,
    output reg fast_clk_run_o,
    output reg slow_clk_run_o,
    output reg fast_oscillator_enable_o,
    output reg system_clock_source_select_o
);
    localparam [3:0] ST_RUN = 4'b0001;
    localparam [3:0] ST_HALT = 4'b0010;
    localparam [3:0] ST_HALTH = 4'b0100;
    localparam [3:0] ST_STOP = 4'b1000;
    localparam [1:0] UL_IDLE = 2'b01;
    localparam [1:0] UL_FIRST = 2'b10;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [1:0] unlock_reg;
    reg [1:0] unlock_next;
    reg armed_reg;
    reg armed_next;
    reg fosc_reg;
    reg fosc_next;
    reg sel_reg;
    reg sel_next;
    reg cpu_run_next;
    reg fast_run_next;
    reg slow_run_next;

    wire [15:0] rst_two_q;
    wire [15:0] rst_three_q;
    wire [15:0] ckg_two_q;
    wire [15:0] ckg_three_q;
    reg wr_rst_two;
    reg wr_rst_three;
    reg wr_ckg_two;
    reg wr_ckg_three;
    reg wr_stby;
    reg wr_unlock;
    reg wr_clk;
    wire req_halt;
    wire req_halth;
    wire req_stop;
    wire halt_wake;
    wire stop_wake;
    reg [15:0] rd_mux;

    // Product variants drop bits through the availability masks
    localparam [15:0] MASK_TWO =
        `BRSC_RST_TWO_MASK & RST_TWO_AVAIL; // see RQ1 see RQ3
    localparam [15:0] MASK_THREE =
        `BRSC_RST_THREE_MASK & RST_THREE_AVAIL; // see RQ1 see RQ4

    // Write select; the control registers only take the low byte lane
    always @* begin
        wr_rst_two = 1'b0;
        wr_rst_three = 1'b0;
        wr_ckg_two = 1'b0;
        wr_ckg_three = 1'b0;
        wr_stby = 1'b0;
        wr_unlock = 1'b0;
        wr_clk = 1'b0;
        if (wr_i) begin
            // Unmapped addresses select nothing, so the write is dropped
            if (addr_i == `BRSC_OFF_RST_TWO) begin
                wr_rst_two = 1'b1;
            end else if (addr_i == `BRSC_OFF_RST_THREE) begin
                wr_rst_three = 1'b1;
            end else if (addr_i == `BRSC_OFF_CKG_TWO) begin
                wr_ckg_two = 1'b1;
            end else if (addr_i == `BRSC_OFF_CKG_THREE) begin
                wr_ckg_three = 1'b1;
            end else if (addr_i == `BRSC_OFF_STBY) begin
                wr_stby = byte_en_i[0];
            end else if (addr_i == `BRSC_OFF_UNLOCK) begin
                wr_unlock = byte_en_i[0];
            end else if (addr_i == `BRSC_OFF_CLKCTL) begin
                wr_clk = byte_en_i[0];
            end
        end
    end

    brsc_rst_reg #(
        .IMPL_MASK(MASK_TWO)
    ) u_rst_two (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_rst_two),
        .lane_i(byte_en_i),
        .wdata_i(wdata_i),
        .q_o(rst_two_q)
    ); // see RQ2 see RQ5 see RQ20

    brsc_rst_reg #(
        .IMPL_MASK(MASK_THREE)
    ) u_rst_three (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_rst_three),
        .lane_i(byte_en_i),
        .wdata_i(wdata_i),
        .q_o(rst_three_q)
    ); // see RQ2 see RQ5 see RQ20

    // Gate registers share the same layout as the reset registers
    brsc_rst_reg #(
        .IMPL_MASK(MASK_TWO)
    ) u_ckg_two (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_ckg_two),
        .lane_i(byte_en_i),
        .wdata_i(wdata_i),
        .q_o(ckg_two_q)
    ); // see RQ7

    brsc_rst_reg #(
        .IMPL_MASK(MASK_THREE)
    ) u_ckg_three (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_ckg_three),
        .lane_i(byte_en_i),
        .wdata_i(wdata_i),
        .q_o(ckg_three_q)
    ); // see RQ7

    assign req_halt = wr_stby && wdata_i[`BRSC_STBY_HALT_BIT];
    assign req_halth = wr_stby && wdata_i[`BRSC_STBY_HALTH_BIT];
    // Stop only counts after a complete unlock
    assign req_stop = wr_stby && wdata_i[`BRSC_STBY_STOP_BIT]
        && armed_reg; // see RQ16 see RQ19
    // Wake sources are levels already in this clock domain
    assign halt_wake = wdt_irq_i || enabled_irq_i; // see RQ11 see RQ13
    // Watchdog and internal irqs are dead without clocks
    assign stop_wake = ext_irq_i || vls_irq_i || cmp_irq_i
        || i2c_slave_irq_i; // see RQ18

    // Unlock sequencer; master irq disable is left to software, see RQ17
    always @* begin
        unlock_next = unlock_reg;
        armed_next = armed_reg;
        if (wr_unlock) begin
            if (wdata_i[7:4] == `BRSC_UNLOCK_FIRST) begin
                unlock_next = UL_FIRST;
                armed_next = 1'b0;
            end else if (wdata_i[7:4] == `BRSC_UNLOCK_SECOND
                && unlock_reg == UL_FIRST) begin
                unlock_next = UL_IDLE;
                armed_next = 1'b1; // see RQ16
            end else begin
                unlock_next = UL_IDLE;
                armed_next = 1'b0; // see RQ19
            end
        end else if (wr_stby) begin
            // Any standby write consumes the arming
            armed_next = 1'b0;
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            unlock_reg <= UL_IDLE;
            armed_reg <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
            armed_reg <= armed_next;
        end
    end

    // Mode sequencer; halt has priority over halt-h over stop
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (req_halt) begin
                    state_next = ST_HALT; // see RQ10
                end else if (req_halth) begin
                    state_next = ST_HALTH; // see RQ12
                end else if (req_stop) begin
                    state_next = ST_STOP; // see RQ15
                end
            end
            ST_HALT: begin
                if (halt_wake) begin
                    state_next = ST_RUN; // see RQ9 see RQ11
                end
            end
            ST_HALTH: begin
                if (halt_wake) begin
                    state_next = ST_RUN; // see RQ9 see RQ13
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    state_next = ST_RUN; // see RQ9 see RQ18
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_RUN; // see RQ8
        end else begin
            state_reg <= state_next;
        end
    end

    // Clock source control; HALT-H exit overrides software values
    always @* begin
        fosc_next = fosc_reg;
        sel_next = sel_reg;
        if (state_reg == ST_HALTH && halt_wake) begin
            fosc_next = 1'b1; // see RQ14
            sel_next = 1'b1; // see RQ14
        end else if (wr_clk) begin
            fosc_next = wdata_i[`BRSC_CLK_FOSC_BIT];
            sel_next = wdata_i[`BRSC_CLK_SEL_BIT];
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fosc_reg <= 1'b0;
            sel_reg <= 1'b0;
        end else begin
            fosc_reg <= fosc_next;
            sel_reg <= sel_next;
        end
    end

    always @* begin
        rd_mux = 16'h0000;
        if (addr_i == `BRSC_OFF_RST_TWO) begin
            rd_mux = rst_two_q;
        end else if (addr_i == `BRSC_OFF_RST_THREE) begin
            rd_mux = rst_three_q;
        end else if (addr_i == `BRSC_OFF_CKG_TWO) begin
            rd_mux = ckg_two_q;
        end else if (addr_i == `BRSC_OFF_CKG_THREE) begin
            rd_mux = ckg_three_q;
        end else if (addr_i == `BRSC_OFF_UNLOCK) begin
            rd_mux = {15'h0000, armed_reg};
        end else if (addr_i == `BRSC_OFF_CLKCTL) begin
            rd_mux = {14'h0000, sel_reg, fosc_reg};
        end else if (addr_i == `BRSC_OFF_MODE) begin
            rd_mux = {12'h000, state_reg};
        end
    end

    // Peripheral lines trail the registers by one cycle, glitch free
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            block_reset_ctrl_two_o <= 16'h0000;
            block_reset_ctrl_three_o <= 16'h0000;
            block_clock_gate_two_o <= 16'h0000;
            block_clock_gate_three_o <= 16'h0000;
        end else begin
            block_reset_ctrl_two_o <= rst_two_q; // see RQ2
            block_reset_ctrl_three_o <= rst_three_q; // see RQ2
            block_clock_gate_two_o <= ckg_two_q; // see RQ7
            block_clock_gate_three_o <= ckg_three_q; // see RQ7
        end
    end

    // Mode flags use the next state so they move with state_reg
    always @* begin
        cpu_run_next = (state_next == ST_RUN); // see RQ10 see RQ12
        fast_run_next = fosc_reg && (state_next == ST_RUN
            || state_next == ST_HALT); // see RQ12 see RQ15
        slow_run_next = (state_next != ST_STOP); // see RQ15
    end

    // Registered outputs; read data stands one cycle after each cycle that rd_i is high, zero otherwise
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
            cpu_run_o <= 1'b1;
            fast_clk_run_o <= 1'b0;
            slow_clk_run_o <= 1'b1;
            fast_oscillator_enable_o <= 1'b0;
            system_clock_source_select_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
            cpu_run_o <= cpu_run_next;
            fast_clk_run_o <= fast_run_next;
            slow_clk_run_o <= slow_run_next;
            fast_oscillator_enable_o <= fosc_reg;
            system_clock_source_select_o <= sel_reg;
        end
    end
endmodule // brsc_top

/* File: bench/brsc_props.sv */
// Assertions on the reset/standby block, bound to its top module
// Assumes one clock domain and the register header on the include path
`include "brsc_regs.vh"
module brsc_props (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire [15:0] addr_i,
    input wire [15:0] wdata_i,
    input wire [1:0] byte_en_i,
    input wire wr_i,
    input wire wdt_irq_i,
    input wire enabled_irq_i,
    input wire ext_irq_i,
    input wire vls_irq_i,
    input wire cmp_irq_i,
    input wire i2c_slave_irq_i,
    input wire [15:0] block_reset_ctrl_two_o,
    input wire [15:0] block_reset_ctrl_three_o,
    input wire cpu_run_o,
    input wire fast_clk_run_o,
    input wire slow_clk_run_o,
    input wire fast_oscillator_enable_o,
    input wire system_clock_source_select_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire stby_wr = wr_i && byte_en_i[0] && addr_i == `BRSC_OFF_STBY;
    wire unl_wr = wr_i && byte_en_i[0] && addr_i == `BRSC_OFF_UNLOCK;
    wire stop_src = ext_irq_i | vls_irq_i | cmp_irq_i | i2c_slave_irq_i;
    wire halt_src = wdt_irq_i | enabled_irq_i;
    // Only a fast-off halt may force the oscillator on at exit
    reg fastoff_reg;
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            fastoff_reg <= 1'h0;
        else if (cpu_run_o)
            fastoff_reg <= stby_wr && wdata_i[1:0] == 2'h2;
    end
    sequence unlock_seq;
        unl_wr && wdata_i[7:4] == `BRSC_UNLOCK_FIRST ##[1:2]
        unl_wr && wdata_i[7:4] == `BRSC_UNLOCK_SECOND;
    endsequence
    sequence stop_wr;
        stby_wr && wdata_i[2:0] == 3'h4 && cpu_run_o;
    endsequence
    a_reserved_zero:
    assert property ((block_reset_ctrl_two_o & ~`BRSC_RST_TWO_MASK) == 16'h0
        && (block_reset_ctrl_three_o & ~`BRSC_RST_THREE_MASK) == 16'h0)
        else $error("reserved reset bit set");
    a_halt_stops_cpu:
    assert property (stby_wr && wdata_i[0] && cpu_run_o |=>
        !cpu_run_o && slow_clk_run_o) else $error("halt entry wrong");
    a_halth_stops_fast:
    assert property (stby_wr && wdata_i[1:0] == 2'h2 && cpu_run_o |=>
        !cpu_run_o && !fast_clk_run_o) else $error("fast-off entry wrong");
    a_halt_wakes:
    assert property (!cpu_run_o && slow_clk_run_o && halt_src |=> cpu_run_o)
        else $error("halt not released");
    a_halth_exit_forces:
    assert property (fastoff_reg && !cpu_run_o && halt_src |-> ##[1:2]
        (fast_oscillator_enable_o && system_clock_source_select_o))
        else $error("fast clock not forced on");
    a_unlock_arms_stop:
    assert property (unlock_seq ##[1:2] stop_wr |=> !slow_clk_run_o)
        else $error("stop not entered");
    a_stop_wakes:
    assert property (!slow_clk_run_o && stop_src |=> cpu_run_o)
        else $error("stop not released");
    a_stop_deaf:
    assert property (!slow_clk_run_o && !stop_src |=> !slow_clk_run_o &&
        !cpu_run_o && !fast_clk_run_o) else $error("stop left early");
endmodule // brsc_props
bind brsc_top brsc_props u_props (.core_clk_i, .rst_b_i, .addr_i, .wdata_i,
    .byte_en_i, .wr_i, .wdt_irq_i, .enabled_irq_i, .ext_irq_i, .vls_irq_i,
    .cmp_irq_i, .i2c_slave_irq_i, .block_reset_ctrl_two_o,
    .block_reset_ctrl_three_o, .cpu_run_o, .fast_clk_run_o, .slow_clk_run_o,
    .fast_oscillator_enable_o, .system_clock_source_select_o);

/* File: bench/brsc_wake_model.sv */
// Wake-source model: watchdog, enabled irq and the four STOP wakers
// Assumes one-cycle request pulses from the bench on the core clock
module brsc_wake_model (
    input wire core_clk_i,
    input wire rst_b_i,
    input wire cpu_run_i,
    input wire [5:0] req_i,
    output reg [5:0] irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Raw lines held till the core runs; masking is the core's
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            irq_o <= 6'h00;
        else if (cpu_run_i)
            irq_o <= req_i;
        else
            irq_o <= irq_o | req_i;
    end
endmodule // brsc_wake_model

/* File: bench/tb_top.sv */
// Bench: register access, standby entry and wake-up of the reset block
// Assumes the register header on the include path and a 10 MHz clock
`include "brsc_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] rst2 = `BRSC_OFF_RST_TWO;
    localparam logic [15:0] stby = `BRSC_OFF_STBY;
    localparam logic [15:0] unl = `BRSC_OFF_UNLOCK;
    logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [15:0] addr = 16'h0, wd = 16'h0;
    logic [1:0] be = 2'h3;
    logic [5:0] req = 6'h00;
    wire [5:0] irq;
    wire [15:0] rdata, two, three, g2, g3;
    wire run, fast, slow, fosc, sel;
    int failures = 0, tests_run = 0;
    brsc_top #(.RST_THREE_AVAIL(16'hFFF7)) DUT (.core_clk_i(clk),
        .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wd), .byte_en_i(be),
        .wr_i(wr), .rd_i(rd), .wdt_irq_i(irq[0]), .enabled_irq_i(irq[1]),
        .ext_irq_i(irq[2]), .vls_irq_i(irq[3]), .cmp_irq_i(irq[4]),
        .i2c_slave_irq_i(irq[5]), .rdata_o(rdata),
        .block_reset_ctrl_two_o(two), .block_reset_ctrl_three_o(three),
        .block_clock_gate_two_o(g2), .block_clock_gate_three_o(g3),
        .cpu_run_o(run), .fast_clk_run_o(fast), .slow_clk_run_o(slow),
        .fast_oscillator_enable_o(fosc), .system_clock_source_select_o(sel));
    brsc_wake_model WAKE (.core_clk_i(clk), .rst_b_i(rst_b), .cpu_run_i(run),
        .req_i(req), .irq_o(irq));
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, g);
        chk_reg(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr16(input logic [15:0] a, d, input logic [1:0] b = 2'h3);
        @(posedge clk);
        addr <= a;
        wd <= d;
        be <= b;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk_reg(nm, e, rdata);
    endtask
    // Bounded wait: a missing wake must not hang the run
    task automatic wake(input int s, input logic e);
        @(posedge clk);
        req[s] <= 1'h1;
        @(posedge clk);
        req <= 6'h00;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (run === 1'h1) break;
        end
        chk_flag("cpu_run", e, run);
    endtask
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        #1 chk_flag("cpu_run", 1'h1, run);
        rdchk("two", rst2, 16'h0);
        rdchk("three", `BRSC_OFF_RST_THREE, 16'h0);
        rdchk("gate", `BRSC_OFF_CKG_TWO, 16'h0);
        rdchk("mode", `BRSC_OFF_MODE, 16'h0001);
        wr16(rst2, 16'hFFFF);
        rdchk("two", rst2, 16'hE83F);
        chk_reg("two_o", 16'hE83F, two);
        wr16(`BRSC_OFF_RST_THREE, 16'hFFFF);
        rdchk("three", `BRSC_OFF_RST_THREE, 16'h0037);
        chk_reg("three_o", 16'h0037, three);
        wr16(rst2, 16'h0000, 2'h1);
        rdchk("two", rst2, 16'hE800);
        wr16(rst2, 16'h17C0, 2'h2);
        rdchk("two", rst2, 16'h0);
        wr16(rst2, 16'h0001);
        wr16(`BRSC_OFF_CKG_TWO, 16'h0001);
        rdchk("gate", `BRSC_OFF_CKG_TWO, 16'h0001);
        chk_reg("gate_o", 16'h0001, g2);
        chk_reg("two_o", 16'h0001, two);
        wr16(`BRSC_OFF_CKG_TWO, 16'h0000);
        wr16(rst2, 16'h0000);
        rdchk("unmapped", 16'hF000, 16'h0);
        chk_reg("two_o", 16'h0, two);
        wr16(`BRSC_OFF_CKG_THREE, 16'hFFFF);
        rdchk("gate3", `BRSC_OFF_CKG_THREE, 16'h0037);
        chk_reg("gate3_o", 16'h0037, g3);
        wr16(`BRSC_OFF_CLKCTL, 16'h0001);
        wr16(stby, 16'h0001);
        chk_flag("cpu_run", 1'h0, run);
        chk_flag("fast_run", 1'h1, fast);
        wake(0, 1'h1);
        wr16(stby, 16'h0001);
        wake(1, 1'h1);
        wr16(`BRSC_OFF_CLKCTL, 16'h0000);
        wr16(stby, 16'h0002);
        chk_flag("slow_run", 1'h1, slow);
        wake(1, 1'h1);
        rdchk("clk_ctl", `BRSC_OFF_CLKCTL, 16'h0003);
        chk_flag("fast_run", 1'h1, fast);
        chk_flag("fosc", 1'h1, fosc);
        wr16(stby, 16'h0004);
        chk_flag("cpu_run", 1'h1, run);
        wr16(unl, 16'h0050);
        wr16(unl, 16'h0030);
        wr16(unl, 16'h00A0);
        wr16(stby, 16'h0004);
        chk_flag("cpu_run", 1'h1, run);
        for (int s = 2; s < 6; s++) begin
            wr16(unl, 16'h005B);
            wr16(unl, 16'h00A4);
            if (s == 2) rdchk("armed", unl, 16'h0001);
            wr16(stby, 16'h0004);
            chk_flag("slow_run", 1'h0, slow);
            if (s == 2) wake(0, 1'h0);
            wake(s, 1'h1);
        end
        chk_flag("sel", 1'h1, sel);
        close_out;
    end
endmodule // tb_top
